/* brag_cpu_model.sv */
// Operand pipeline model that issues X write requests
`timescale 1ns/10ps
module brag_cpu_model
  import brag_pkg::*;
(
  input wire logic i_clk,
  output brag_req_s o_req,
  output logic o_req_is_read,
  output logic [15:0] o_mod_addr,
  output logic o_mod_hit
);
  brag_req_s rel;
  initial begin
    o_req = '0;
    o_req_is_read = 1'b0;
    o_mod_addr = 16'hBEEF;
    o_mod_hit = 1'b0;
  end
  // One request held for one cycle, then scrambled so stale fields never look valid
  task automatic issue(input logic b, input logic [3:0] w, input brag_amode_e m,
                       input logic [15:0] p, input logic rd, input logic hit);
    @(posedge i_clk);
    o_req <= '{1'b1, b, w, m, p, 16'h0006};
    o_req_is_read <= rd;
    o_mod_hit <= hit;
    @(posedge i_clk);
    rel = brag_req_s'(~o_req);
    rel.valid = 1'b0;
    o_req <= rel;
    o_mod_hit <= ~hit;
  endtask : issue
endmodule : brag_cpu_model

/* brag_pkg.sv */
// Package for the bit-reversed X write address generator
package brag_pkg;
  localparam logic [3:0] BRAG_OFF_CONTROL = 4'h0;
  localparam logic [3:0] BRAG_OFF_MODE = 4'h4;
  localparam logic [3:0] BRAG_OFF_STATUS = 4'h8;
  localparam logic [3:0] BRAG_OFF_REVWR = 4'hC;
  localparam logic [15:0] BRAG_CONTROL_RST = 16'h0000;
  localparam logic [15:0] BRAG_MODE_RST = 16'h00FF;
  localparam int BRAG_ENABLE_BIT = 15;
  localparam int BRAG_MOD_MSB = 14;
  localparam int BRAG_XWM_LSB = 0;
  localparam int BRAG_YWM_LSB = 4;
  localparam int BRAG_PSEL_LSB = 8;
  localparam int BRAG_XMODEN_BIT = 15;
  localparam logic [3:0] BRAG_SP_REG = 4'hF;

  typedef enum logic [2:0] {
    BRAG_AM_DIRECT = 3'h0,
    BRAG_AM_IND = 3'h1,
    BRAG_AM_POSTINC = 3'h2,
    BRAG_AM_POSTDEC = 3'h3,
    BRAG_AM_PREINC = 3'h4,
    BRAG_AM_PREDEC = 3'h5,
    BRAG_AM_REGOFF = 3'h6,
    BRAG_AM_LITOFF = 3'h7
  } brag_amode_e;

  typedef enum logic [1:0] {
    BRAG_ST_IDLE = 2'b01,
    BRAG_ST_ACK = 2'b10
  } brag_bus_e;

  // One X write request from the operand pipeline
  typedef struct packed {
    logic valid;
    logic is_byte;
    logic [3:0] wreg;
    brag_amode_e amode;
    logic [15:0] ptr;
    logic [15:0] offset;
  } brag_req_s;

  // Result towards the data memory and the pointer writeback
  typedef struct packed {
    logic valid;
    logic bitrev;
    logic [15:0] addr;
    logic wb_en;
    logic [15:0] wb_val;
  } brag_rsp_s;
endpackage : brag_pkg

/* brag_revadd.sv */
// Reverse-carry adder: carries ripple from high word bits to low ones
`timescale 1ns/10ps
module brag_revadd
  import brag_pkg::*;
(
  input wire logic [15:0] i_ptr,
  input wire logic [14:0] i_mod,
  output logic [15:0] o_sum
);
  logic [15:0] mod_byte;
  logic [15:0] carry;
  logic [15:0] sum;
  assign mod_byte = {i_mod, 1'b0};
  assign carry[15] = 1'b0;
  assign sum[0] = 1'b0;
  genvar g;
  generate
    for (g = 15; g >= 1; g--) begin : g_bit
      assign sum[g] = i_ptr[g] ^ mod_byte[g] ^ carry[g];
      if (g > 1) begin : g_c
        assign carry[g-1] = (i_ptr[g] & mod_byte[g]) | (carry[g] & (i_ptr[g] ^ mod_byte[g]));
      end
    end
  endgenerate
  assign carry[0] = 1'b0;
  assign o_sum = sum;
endmodule : brag_revadd

/* brag_top.sv */
// X write address generator with bit-reversed addressing and an Avalon-MM slave
`timescale 1ns/10ps
module brag_top
  import brag_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire brag_req_s i_req,
  input wire logic i_req_is_read,
  input wire logic [15:0] i_mod_addr,
  input wire logic i_mod_hit,
  output brag_rsp_s o_rsp,
  output logic o_xrd_modulo_en,
  output logic o_xwr_modulo_en
);
  logic [15:0] control_q;
  logic [15:0] mode_q;
  logic [15:0] revcnt_q;
  brag_bus_e bus_q;
  logic [31:0] rdata_q;
  brag_rsp_s rsp_q;

  // Bus decode
  wire bus_req = i_avs_read | i_avs_write;
  wire bus_done = (bus_q == BRAG_ST_ACK);
  wire wr_ctl = bus_done & i_avs_write & (i_avs_address == BRAG_OFF_CONTROL);
  wire wr_mode = bus_done & i_avs_write & (i_avs_address == BRAG_OFF_MODE);
  wire wr_cnt = bus_done & i_avs_write & (i_avs_address == BRAG_OFF_REVWR);
  assign o_avs_waitrequest = bus_req & ~bus_done;
  assign o_avs_readdata = rdata_q;

  // Enable decode
  wire [3:0] psel = mode_q[BRAG_PSEL_LSB +: 4];
  wire [3:0] xwm = mode_q[BRAG_XWM_LSB +: 4];
  wire psel_ok = (psel != BRAG_SP_REG);
  wire br_on = control_q[BRAG_ENABLE_BIT] & psel_ok;
  wire inc_mode = (i_req.amode == BRAG_AM_PREINC) | (i_req.amode == BRAG_AM_POSTINC);
  wire br_act = br_on & inc_mode & ~i_req.is_byte & ~i_req_is_read
                & (i_req.wreg == psel);
  wire xmod_on = mode_q[BRAG_XMODEN_BIT] & (xwm != BRAG_SP_REG);
  assign o_xrd_modulo_en = xmod_on;
  assign o_xwr_modulo_en = xmod_on & ~br_act;

  // Address paths
  logic [15:0] rev_sum;
  brag_revadd i_brag_revadd (
    .i_ptr(i_req.ptr),
    .i_mod(control_q[BRAG_MOD_MSB:0]),
    .o_sum(rev_sum)
  );
  wire [15:0] inc_ptr = i_req.ptr + i_req.offset;
  wire [15:0] dec_ptr = i_req.ptr - i_req.offset;
  wire pre_m = (i_req.amode == BRAG_AM_PREINC) | (i_req.amode == BRAG_AM_PREDEC);
  wire post_m = (i_req.amode == BRAG_AM_POSTINC) | (i_req.amode == BRAG_AM_POSTDEC);
  wire inc_dir = (i_req.amode == BRAG_AM_PREINC) | (i_req.amode == BRAG_AM_POSTINC);
  wire [15:0] mod_ptr = inc_dir ? inc_ptr : dec_ptr;
  wire [15:0] fixed_ptr = (o_xwr_modulo_en & i_mod_hit) ? i_mod_addr : mod_ptr;
  wire off_m = (i_req.amode == BRAG_AM_REGOFF) | (i_req.amode == BRAG_AM_LITOFF);
  wire [15:0] norm_addr = (pre_m | off_m) ? ((pre_m) ? fixed_ptr : inc_ptr) : i_req.ptr;
  wire [15:0] effective_addr = br_act ? rev_sum : norm_addr;
  wire [15:0] wb = br_act ? rev_sum : fixed_ptr;
  wire wb_en = pre_m | post_m;

  // Read mux
  logic [31:0] rmux;
  assign rmux = (i_avs_address == BRAG_OFF_CONTROL) ? {16'h0000, control_q} :
                (i_avs_address == BRAG_OFF_MODE) ? {16'h0000, mode_q} :
                (i_avs_address == BRAG_OFF_STATUS) ? {30'h0, br_act, br_on} :
                (i_avs_address == BRAG_OFF_REVWR) ? {16'h0000, revcnt_q} : 32'h00000000;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bus_q <= BRAG_ST_IDLE;
      rdata_q <= 32'h00000000;
    end else begin
      unique case (bus_q)
        BRAG_ST_IDLE: begin
          if (bus_req) begin
            bus_q <= BRAG_ST_ACK;
            rdata_q <= rmux;
          end
        end
        BRAG_ST_ACK: begin
          bus_q <= BRAG_ST_IDLE;
        end
        default: bus_q <= BRAG_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      control_q <= BRAG_CONTROL_RST;
      mode_q <= BRAG_MODE_RST;
    end else begin
      if (wr_ctl) control_q <= i_avs_writedata[15:0];
      if (wr_mode) mode_q <= i_avs_writedata[15:0];
    end
  end

  // Count of bit-reversed writes; hardware increment wins over software clear
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      revcnt_q <= 16'h0000;
    end else if (i_req.valid & br_act) begin
      revcnt_q <= revcnt_q + 16'h0001;
    end else if (wr_cnt) begin
      revcnt_q <= 16'h0000;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rsp_q <= '0;
    end else begin
      rsp_q.valid <= i_req.valid;
      rsp_q.bitrev <= i_req.valid & br_act;
      rsp_q.addr <= effective_addr;
      rsp_q.wb_en <= i_req.valid & wb_en;
      rsp_q.wb_val <= wb;
    end
  end
  assign o_rsp = rsp_q;

  // Next address of a 16-word buffer: mirror the word index, add one, mirror back
  wire [3:0] idx_rev = {i_req.ptr[1], i_req.ptr[2], i_req.ptr[3], i_req.ptr[4]};
  wire [3:0] idx_rev_nxt = idx_rev + 4'h1;
  wire [15:0] mirror_nxt = {i_req.ptr[15:5], idx_rev_nxt[0], idx_rev_nxt[1], idx_rev_nxt[2],
                            idx_rev_nxt[3], 1'b0};

  sequence s_rev_req;
    i_req.valid && br_act;
  endsequence

  sequence s_ind_req;
    i_req.valid && !br_act && (i_req.amode == BRAG_AM_IND);
  endsequence

  a_rev_lsb_zero: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    rsp_q.bitrev
    |-> (rsp_q.addr[0] == 1'b0))
  else $error("bitrev addr lsb set");

  a_sp_no_rev: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req.valid && (psel == BRAG_SP_REG))
    |=> !rsp_q.bitrev)
  else $error("rev with sp select");

  a_en_needed: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req.valid && !control_q[BRAG_ENABLE_BIT])
    |=> !rsp_q.bitrev)
  else $error("rev while off");

  a_byte_normal: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req.valid && i_req.is_byte)
    |=> !rsp_q.bitrev)
  else $error("byte rev");

  a_read_normal: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req.valid && i_req_is_read)
    |=> !rsp_q.bitrev)
  else $error("read rev");

  a_mode_gate: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req.valid && !inc_mode)
    |=> !rsp_q.bitrev)
  else $error("wrong mode rev");

  a_ind_plain: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    s_ind_req
    |=> ((rsp_q.addr == $past(i_req.ptr)) && !rsp_q.wb_en))
  else $error("plain indirect address");

  a_prio_mod: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (br_act && mode_q[BRAG_XMODEN_BIT] && (xwm != BRAG_SP_REG))
    |-> (!o_xwr_modulo_en && o_xrd_modulo_en))
  else $error("modulo prio");

  a_sum_ptr: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req.valid && br_act && (control_q[BRAG_MOD_MSB:0] == 15'h0001))
    |=> (rsp_q.addr == {$past(i_req.ptr[15:2]), ~$past(i_req.ptr[1]), 1'b0}))
  else $error("two word pivot sum");

  a_wb_rev: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    s_rev_req
    |=> (rsp_q.wb_en && (rsp_q.wb_val == rsp_q.addr)))
  else $error("rev writeback");

  a_mirror_8: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req.valid && br_act && (control_q[BRAG_MOD_MSB:0] == 15'h0008))
    |=> (rsp_q.addr == $past(mirror_nxt)))
  else $error("mirror sequence");

  a_bus_wait: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (bus_req && (bus_q == BRAG_ST_IDLE))
    |=> !o_avs_waitrequest)
  else $error("bus late");
endmodule : brag_top

/* brag_top_test.sv */
// Self-checking bench for the bit-reversed X write address generator
`timescale 1ns/10ps
module brag_top_test;
  import brag_pkg::*;
  logic i_clk, i_arst_n, rd, wr, wreq, req_rd, hit, xrd_en, xwr_en;
  logic [3:0] adr;
  logic [15:0] maddr, p, exp_addr, exp_wb;
  brag_amode_e m;
  logic [31:0] wdat, rdat, avs_rdata;
  brag_req_s req;
  brag_rsp_s rsp;
  int err_total, n_checks;
  brag_top i_brag_top (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(avs_rdata),
    .o_avs_waitrequest(wreq), .i_req(req), .i_req_is_read(req_rd), .i_mod_addr(maddr),
    .i_mod_hit(hit), .o_rsp(rsp), .o_xrd_modulo_en(xrd_en), .o_xwr_modulo_en(xwr_en));
  brag_cpu_model i_brag_cpu_model (.i_clk(i_clk), .o_req(req), .o_req_is_read(req_rd),
    .o_mod_addr(maddr), .o_mod_hit(hit));
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge i_clk);
      if (wreq === 1'b0) break;
    end
    rdat = avs_rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    #1;
    if (k == 20) begin
      err_total++;
      test_done();
    end
  endtask : bus
  function automatic logic [3:0] mir(input logic [3:0] i);
    return {i[0], i[1], i[2], i[3]};
  endfunction : mir
  task automatic rsp_chk(input logic f, input logic [15:0] a, input logic we,
                         input logic [15:0] wv);
    #1;
    chk("rsp_valid", 32'h1, {31'h0, rsp.valid});
    chk("rsp_bitrev", {31'h0, f}, {31'h0, rsp.bitrev});
    chk("rsp_addr", {16'h0, a}, {16'h0, rsp.addr});
    chk("rsp_wb_en", {31'h0, we}, {31'h0, rsp.wb_en});
    if (we) chk("rsp_wb_val", {16'h0, wv}, {16'h0, rsp.wb_val});
  endtask : rsp_chk
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    i_arst_n = 1'b0;
    {rd, wr, adr, wdat, err_total, n_checks} = '0;
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1'b1;
    bus(1'b0, BRAG_OFF_CONTROL, 32'h0);
    chk("control_rst", 32'h0, rdat);
    bus(1'b0, BRAG_OFF_MODE, 32'h0);
    chk("mode_rst", {16'h0, BRAG_MODE_RST}, rdat);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, rdat);
    bus(1'b1, BRAG_OFF_MODE, 32'h0000_8303);
    bus(1'b1, BRAG_OFF_CONTROL, 32'h0000_8008);
    // Aligned 16-word buffer; odd start pointer shows the address LSB is dropped
    p = 16'h0101;
    for (int k = 0; k < 16; k++) begin
      fork
        i_brag_cpu_model.issue(1'b0, 4'h3, k[0] ? BRAG_AM_PREINC : BRAG_AM_POSTINC, p,
                               1'b0, 1'b1);
        begin
          @(posedge i_clk);
          #1;
          chk("xwr_mod", 32'h0, {31'h0, xwr_en});
          chk("xrd_mod", 32'h1, {31'h0, xrd_en});
        end
      join
      p = 16'h0100 | {11'h0, mir(4'(k + 1)), 1'b0};
      rsp_chk(1'b1, p, 1'b1, p);
    end
    bus(1'b0, BRAG_OFF_REVWR, 32'h0);
    chk("rev_count", 32'h10, rdat);
    bus(1'b1, BRAG_OFF_REVWR, 32'h0);
    bus(1'b0, BRAG_OFF_REVWR, 32'h0);
    chk("rev_clear", 32'h0, rdat);
    // Byte, plain indirect, read, other pointer, pre-decrement, literal offset
    for (int k = 0; k < 6; k++) begin
      m = BRAG_AM_POSTINC;
      if (k == 1) m = BRAG_AM_IND;
      if (k == 4) m = BRAG_AM_PREDEC;
      if (k == 5) m = BRAG_AM_LITOFF;
      exp_addr = k == 4 ? 16'h023A : (k == 5 ? 16'h0246 : 16'h0240);
      exp_wb = k == 4 ? 16'h023A : 16'h0246;
      i_brag_cpu_model.issue(k == 0, k == 3 ? 4'h4 : 4'h3, m, 16'h0240, k == 2, 1'b0);
      rsp_chk(1'b0, exp_addr, k != 1 && k != 5, exp_wb);
    end
    // Two-word pivot; pending modulo correction must lose to bit-reversal
    bus(1'b1, BRAG_OFF_CONTROL, 32'h0000_8001);
    i_brag_cpu_model.issue(1'b0, 4'h3, BRAG_AM_PREINC, 16'h0245, 1'b0, 1'b1);
    rsp_chk(1'b1, 16'h0246, 1'b1, 16'h0246);
    bus(1'b1, BRAG_OFF_CONTROL, 32'h0000_0008);
    chk("xwr_mod_on", 32'h1, {31'h0, xwr_en});
    i_brag_cpu_model.issue(1'b0, 4'h3, BRAG_AM_POSTINC, 16'h0300, 1'b0, 1'b0);
    rsp_chk(1'b0, 16'h0300, 1'b1, 16'h0306);
    bus(1'b1, BRAG_OFF_MODE, 32'h0000_0F00);
    bus(1'b1, BRAG_OFF_CONTROL, 32'h0000_8008);
    i_brag_cpu_model.issue(1'b0, 4'hF, BRAG_AM_POSTINC, 16'h0300, 1'b0, 1'b0);
    rsp_chk(1'b0, 16'h0300, 1'b1, 16'h0306);
    // Reset in mid-run clears the response and loads the registers with their reset values
    i_arst_n <= 1'b0;
    @(posedge i_clk);
    #1;
    chk("rsp_rst", 32'h0, {13'h0, rsp.valid, rsp.bitrev, rsp.wb_en, rsp.addr});
    chk("xwr_rst", 32'h0, {31'h0, xwr_en});
    i_arst_n <= 1'b1;
    bus(1'b0, BRAG_OFF_CONTROL, 32'h0);
    chk("control_rerst", 32'h0, rdat);
    test_done();
  end
endmodule : brag_top_test
